// file: core/sensor_ctl_pkg.sv
`default_nettype none
package sensor_ctl_pkg;
	// Pulses sent to the measurement engines
	typedef struct packed {
		logic soft_reset;
		logic autozero;
		logic buffer_clear;
		logic sleep_exit;
		logic mux_start;
	} ctl_pulse_t;
	// Events reported back by the engines
	typedef struct packed {
		logic saturation;
		logic spectral;
		logic buffer_level;
		logic flicker_change;
		logic mux_done;
	} ctl_event_t;
	// APB access decode kinds
	typedef enum logic [2:0] {
		AC_NONE, AC_PIN, AC_ENABLE, AC_LAMP, AC_IEN, AC_CTL, AC_STATUS
	} acc_t;
endpackage : sensor_ctl_pkg
`default_nettype wire

// file: core/sensor_ctl_regs.svh
`ifndef SENSOR_CTL_REGS_SVH
`define SENSOR_CTL_REGS_SVH
// Register indices (the byte address is four times the index)
`define IDX_PIN_CONTROL 8'h6B
`define IDX_ENABLE_BITS 8'h80
`define IDX_LAMP_CONTROL 8'hCD
`define IDX_INTERRUPT_ENABLES 8'hF9
`define IDX_CONTROL_STROBES 8'hFA
// Own status register holding event flags
`define IDX_EVENT_STATUS 8'hFB
// Enable bits field positions
`define EN_POWER_ON 0
`define EN_SPECTRAL 1
`define EN_WAIT 3
`define EN_MUX_LOAD 4
`define EN_FLICKER 6
// Pin control positions
`define PIN_IN 0
`define PIN_OUT 1
`define PIN_IN_EN 2
`define PIN_INV 3
// Lamp positions
`define LAMP_SWITCH 7
// Interrupt enable positions
`define IEN_SYSTEM 0
`define IEN_BUFFER 2
`define IEN_SPECTRAL 3
`define IEN_SATURATION 7
// Control strobe positions
`define CTL_SLEEP_EXIT 0
`define CTL_BUFFER_CLEAR 1
`define CTL_AUTOZERO 2
`define CTL_SOFT_RESET 3
// Reset values
`define RST_ENABLE_BITS 8'h00
`define RST_PIN_CONTROL 8'h02
`define RST_LAMP_CONTROL 8'h04
`define RST_INTERRUPT_ENABLES 8'h00
// Lamp current: base and step in mA
`define LAMP_BASE_MA 4
`define LAMP_STEP_MA 2
`endif

// file: core/sensor_enable_control_regs.sv
`include "sensor_ctl_regs.svh"
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Usage notes
//
// Bus side
// - One register per aligned word, data in the low byte
// - Upper read bits are always zero
// - The slave answers in the access cycle, no wait states
// - Unmapped or unaligned addresses raise the slave error
// - A refused write leaves every register untouched
// - Back-to-back transfers are served without a gap
//
// Enable bits
// - Bits 7, 5 and 2 are spare storage, kept as written
// - Spectral enable reaches the engine only with power on
// - Engine levels follow a write one cycle later
// - The mux start bit stays set while the mux runs
// - Mux completion clears it unless an enable write
//   lands in the very same cycle, which then wins
// - A second start while busy is not pulsed again
//
// Pin control
// - Only bits 3 to 1 are stored, bits 7 to 4 read zero
// - The driven level is the output bit, inverted by bit 3
// - Output enable is low while the input is enabled
// - The input passes a three-stage synchroniser, and a
//   level counts once the last two stages agree
// - Bit 0 reads the synchronised level only when enabled
//
// Lamp control
// - Bit 7 drives the lamp pin directly
// - Bits 6:0 carry the current code to the lamp driver
// - Current grows in fixed steps from the base value
//
// Interrupts
// - Engine events set sticky flags in the status word
// - Software clears flags by writing ones there
// - An event in the clearing cycle keeps its flag set
// - The line rises one cycle after an enabled flag
// - Masking a pending flag drops the line, flag kept
//
// Control strobes
// - All control bits read back as zero
// - Each strobe is a single-cycle pulse to the engines
// - Autozero is withheld while the spectral enable bit is set,
//   since the engine would ignore it anyway
// - Buffer clear also drops the buffer flag
// - Soft reset pulses once, then resets every register
//   one edge after the write; the bus answer survives
//
// Hazards
// - Changing configuration while measuring may spoil
//   the current result; the logic does not block it
// - Soft reset in mid-transfer of another master is not
//   possible here, as there is only one bus
////////////////////////////////////////////////////////////////////////
module sensor_enable_control_regs
	import sensor_ctl_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic mclk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Engine controls
	output logic power_on_bit,
	output logic spectral_measure_enable,
	output logic wait_enable,
	output logic flicker_detect_enable,
	output ctl_pulse_t ctl_pulse,
	// Engine events, same clock
	input wire ctl_event_t engine_event,
	// General purpose pin
	input wire logic gpio_pin_in,
	output logic gpio_pin_out,
	output logic gpio_pin_oe,
	// Lamp driver
	output logic lamp_driver_pin,
	output logic [6:0] lamp_current_code,
	// Interrupt line
	output logic irq
);

	// Address must reach the highest register word
	if (ADDR_W < 10) begin : g_bad_addr_w
		$error("ADDR_W must reach byte address 0x3EC");
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode

	// Map a byte address to a register kind
	function automatic acc_t decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] idx;
		idx = a >> 2;
		if (a[1:0] != 2'b00) begin
			decode = AC_NONE;
		end else if (idx == ADDR_W'(`IDX_PIN_CONTROL)) begin
			decode = AC_PIN;
		end else if (idx == ADDR_W'(`IDX_ENABLE_BITS)) begin
			decode = AC_ENABLE;
		end else if (idx == ADDR_W'(`IDX_LAMP_CONTROL)) begin
			decode = AC_LAMP;
		end else if (idx == ADDR_W'(`IDX_INTERRUPT_ENABLES)) begin
			decode = AC_IEN;
		end else if (idx == ADDR_W'(`IDX_CONTROL_STROBES)) begin
			decode = AC_CTL;
		end else if (idx == ADDR_W'(`IDX_EVENT_STATUS)) begin
			decode = AC_STATUS;
		end else begin
			decode = AC_NONE;
		end
	endfunction : decode

	logic access_phase; // Access phase of a transfer
	logic wr_hit; // Write takes effect this edge
	acc_t kind; // Decoded target
	assign access_phase = psel && penable;
	assign kind = decode(paddr);
	assign wr_hit = access_phase && pwrite;

	////////////////////////////////////////////////////////////////////////
	// Storage

	logic [7:0] enable_q; // Enable bits register
	logic [7:0] pin_q; // Pin control, bit 0 unused here
	logic [7:0] lamp_q; // Lamp control
	logic [7:0] ien_q; // Interrupt enables
	logic [4:0] flags_q; // Event flags: sat, spec, buf, flick, mux
	logic [2:0] pin_sync_q; // Pin input synchroniser
	logic pin_level_q; // Filtered pin level
	logic soft_rst_q; // Registered soft reset
	logic rst_all; // Reset from either source
	assign rst_all = sys_rst || soft_rst_q;

	// Soft reset pulse, self-clearing
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			soft_rst_q <= 1'b0;
		end else if (wr_hit && kind == AC_CTL) begin
			soft_rst_q <= pwdata[`CTL_SOFT_RESET];
		end else begin
			soft_rst_q <= 1'b0;
		end
	end

	// Enable bits register
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			enable_q <= `RST_ENABLE_BITS;
		end else if (wr_hit && kind == AC_ENABLE) begin
			enable_q <= pwdata[7:0];
		end else begin
			if (wr_hit && kind == AC_IEN) begin
				// Wait bit keeps its own value on an interrupt enable write
				enable_q[`EN_WAIT] <= enable_q[`EN_WAIT];
			end
			// Completion is lost to an enable write in the same cycle
			if (engine_event.mux_done) begin
				enable_q[`EN_MUX_LOAD] <= 1'b0;
			end
		end
	end

	// Pin control register
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			pin_q <= `RST_PIN_CONTROL;
		end else if (wr_hit && kind == AC_PIN) begin
			pin_q <= {4'h0, pwdata[3:1], 1'b0};
		end
	end

	// Lamp control register
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			lamp_q <= `RST_LAMP_CONTROL;
		end else if (wr_hit && kind == AC_LAMP) begin
			lamp_q <= pwdata[7:0];
		end
	end

	// Interrupt enables
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			ien_q <= `RST_INTERRUPT_ENABLES;
		end else if (wr_hit && kind == AC_IEN) begin
			ien_q <= {pwdata[7], 3'h0, pwdata[3:2], 1'b0, pwdata[0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin input synchroniser

	// Three stages, change taken when last two agree
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			pin_sync_q <= 3'h0;
			pin_level_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], gpio_pin_in};
			if (pin_sync_q[2] == pin_sync_q[1]) begin
				pin_level_q <= pin_sync_q[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event flags

	logic [4:0] ev_vec; // Incoming events
	logic [4:0] ev_clr; // Write-one-to-clear mask
	assign ev_vec = engine_event;
	assign ev_clr = (wr_hit && kind == AC_STATUS) ? pwdata[4:0] : 5'h00;

	// Sticky flags, set wins over clear
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			flags_q <= 5'h00;
		end else begin
			flags_q <= (flags_q & ~ev_clr) | ev_vec;
			if (wr_hit && kind == AC_CTL && pwdata[`CTL_BUFFER_CLEAR]) begin
				flags_q[2] <= ev_vec[2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control pulses to engines

	// One-cycle strobes from control and enable writes
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			ctl_pulse <= '0;
		end else begin
			ctl_pulse.soft_reset <= wr_hit && kind == AC_CTL &&
				pwdata[`CTL_SOFT_RESET];
			ctl_pulse.autozero <= wr_hit && kind == AC_CTL &&
				pwdata[`CTL_AUTOZERO] && !enable_q[`EN_SPECTRAL];
			ctl_pulse.buffer_clear <= wr_hit && kind == AC_CTL &&
				pwdata[`CTL_BUFFER_CLEAR];
			ctl_pulse.sleep_exit <= wr_hit && kind == AC_CTL &&
				pwdata[`CTL_SLEEP_EXIT];
			ctl_pulse.mux_start <= wr_hit && kind == AC_ENABLE &&
				pwdata[`EN_MUX_LOAD] && !enable_q[`EN_MUX_LOAD];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Engine levels and pins

	// Registered control outputs
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			power_on_bit <= 1'b0;
			spectral_measure_enable <= 1'b0;
			wait_enable <= 1'b0;
			flicker_detect_enable <= 1'b0;
			gpio_pin_out <= 1'b0;
			gpio_pin_oe <= 1'b0;
			lamp_driver_pin <= 1'b0;
			lamp_current_code <= 7'(`RST_LAMP_CONTROL);
		end else begin
			power_on_bit <= enable_q[`EN_POWER_ON];
			spectral_measure_enable <= enable_q[`EN_SPECTRAL] &&
				enable_q[`EN_POWER_ON];
			wait_enable <= enable_q[`EN_WAIT];
			flicker_detect_enable <= enable_q[`EN_FLICKER];
			gpio_pin_out <= pin_q[`PIN_OUT] ^ pin_q[`PIN_INV];
			gpio_pin_oe <= !pin_q[`PIN_IN_EN];
			lamp_driver_pin <= lamp_q[`LAMP_SWITCH];
			lamp_current_code <= lamp_q[6:0];
		end
	end

	// Interrupt line from enabled flags
	always_ff @(posedge mclk) begin
		if (rst_all) begin
			irq <= 1'b0;
		end else begin
			irq <= (flags_q[4] && ien_q[`IEN_SATURATION]) ||
				(flags_q[3] && ien_q[`IEN_SPECTRAL]) ||
				(flags_q[2] && ien_q[`IEN_BUFFER]) ||
				((flags_q[1] || flags_q[0]) && ien_q[`IEN_SYSTEM]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB response

	logic [7:0] rd_byte; // Read mux
	always_comb begin
		rd_byte = 8'h00;
		case (kind)
			AC_PIN: begin
				rd_byte = {pin_q[7:1],
					pin_q[`PIN_IN_EN] & pin_level_q};
			end
			AC_ENABLE: begin
				rd_byte = enable_q;
				rd_byte[`EN_WAIT] = enable_q[`EN_WAIT];
			end
			AC_LAMP: begin
				rd_byte = lamp_q;
			end
			AC_IEN: begin
				rd_byte = ien_q;
			end
			AC_CTL: begin
				rd_byte = 8'h00;
			end
			AC_STATUS: begin
				rd_byte = {3'h0, flags_q};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Zero-wait answer, error on unmapped address
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && kind == AC_NONE;
			prdata <= (psel && !penable && !pwrite) ?
				{24'h000000, rd_byte} : 32'h0000_0000;
		end
	end

endmodule : sensor_enable_control_regs
`default_nettype wire

// file: verification/engine_model.sv
`default_nettype none
module engine_model
	import sensor_ctl_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire ctl_pulse_t ctl_pulse,
	input wire ctl_event_t ev_req,
	output ctl_event_t engine_event
);
	logic [3:0] mux_cnt_q; // Mux busy countdown
	// Mux finishes a few cycles after its start pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mux_cnt_q <= 4'h0;
		end else if (ctl_pulse.mux_start) begin
			mux_cnt_q <= 4'h6;
		end else if (mux_cnt_q != 4'h0) begin
			mux_cnt_q <= mux_cnt_q - 4'h1;
		end
	end
	// Bench events pass through, mux completion added
	always_comb begin
		engine_event = ev_req;
		engine_event.mux_done = (mux_cnt_q == 4'h1);
	end
endmodule : engine_model
`default_nettype wire

// file: verification/sensor_ctl_checker.sv
`default_nettype none
module sensor_ctl_checker
	import sensor_ctl_pkg::*;
#(
	parameter int ADDR_W = 10
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic power_on_bit,
	input wire logic spectral_measure_enable,
	input wire logic wait_enable,
	input wire logic flicker_detect_enable,
	input wire ctl_pulse_t ctl_pulse,
	input wire logic gpio_pin_out,
	input wire logic lamp_driver_pin,
	input wire logic [6:0] lamp_current_code
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic wr; // Write accepted at this edge
	assign wr = psel && penable && pready && pwrite;
	a_flicker_follow: assert property (wr && paddr == 10'h200
		|-> ##2 flicker_detect_enable == $past(pwdata[6], 2))
		else $error("flk");
	a_wait_follow: assert property (wr && paddr == 10'h200
		|-> ##2 wait_enable == $past(pwdata[3], 2)) else $error("wait");
	a_power_follow: assert property (wr && paddr == 10'h200
		|-> ##2 power_on_bit == $past(pwdata[0], 2)) else $error("pon");
	a_spec_power: assert property (spectral_measure_enable
		|-> power_on_bit) else $error("spec without power");
	a_lamp_switch: assert property (wr && paddr == 10'h334
		|-> ##2 lamp_driver_pin == $past(pwdata[7], 2)) else $error("lamp");
	a_lamp_code: assert property (wr && paddr == 10'h334
		|-> ##2 lamp_current_code == $past(pwdata[6:0], 2))
		else $error("code");
	a_pin_invert: assert property (wr && paddr == 10'h1AC
		|-> ##2 gpio_pin_out == ($past(pwdata[1], 2) ^ $past(pwdata[3], 2)))
		else $error("pin out");
	a_clear_pulse: assert property (wr && paddr == 10'h3E8 && pwdata[1]
		|=> ctl_pulse.buffer_clear ##1 !ctl_pulse.buffer_clear)
		else $error("clear pulse");
	a_sleep_pulse: assert property (wr && paddr == 10'h3E8 && pwdata[0]
		|=> ctl_pulse.sleep_exit ##1 !ctl_pulse.sleep_exit)
		else $error("sleep pulse");
endmodule : sensor_ctl_checker
bind sensor_enable_control_regs sensor_ctl_checker #(.ADDR_W(ADDR_W))
	sensor_ctl_checker_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .power_on_bit(power_on_bit),
	.spectral_measure_enable(spectral_measure_enable),
	.wait_enable(wait_enable), .flicker_detect_enable(flicker_detect_enable),
	.ctl_pulse(ctl_pulse), .gpio_pin_out(gpio_pin_out),
	.lamp_driver_pin(lamp_driver_pin), .lamp_current_code(lamp_current_code));
`default_nettype wire

// file: verification/sensor_enable_control_regs_test.sv
`default_nettype none
module sensor_enable_control_regs_test
	import sensor_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic gpio_pin_in = 0, pready, pslverr, err, power_on_bit, irq;
	logic spectral_measure_enable, wait_enable, flicker_detect_enable;
	logic gpio_pin_out, gpio_pin_oe, lamp_driver_pin;
	logic [6:0] lamp_current_code;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	ctl_pulse_t ctl_pulse;
	ctl_event_t engine_event, ev_req = '0;
	int error_cnt = 0, samples_checked = 0;
	always #4 mclk = ~mclk;
	sensor_enable_control_regs #(.ADDR_W(10)) sensor_enable_control_regs_inst (
		.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .power_on_bit(power_on_bit),
		.spectral_measure_enable(spectral_measure_enable),
		.wait_enable(wait_enable), .flicker_detect_enable(flicker_detect_enable),
		.ctl_pulse(ctl_pulse), .engine_event(engine_event),
		.gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out),
		.gpio_pin_oe(gpio_pin_oe), .lamp_driver_pin(lamp_driver_pin),
		.lamp_current_code(lamp_current_code), .irq(irq));
	engine_model engine_model_inst (.mclk(mclk), .sys_rst(sys_rst),
		.ctl_pulse(ctl_pulse), .ev_req(ev_req), .engine_event(engine_event));
	// APB transfer: setup, access held until ready
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic rdchk(string nm, logic [9:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, r);
	endtask : rdchk
	task automatic pulse(ctl_event_t e);
		@(posedge mclk);
		ev_req <= e;
		@(posedge mclk);
		ev_req <= '0;
	endtask : pulse
	task automatic results;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic t_reset;
		rdchk("enable", 10'h200, 32'h0);
		rdchk("pin", 10'h1AC, 32'h2);
		rdchk("lamp", 10'h334, 32'h4);
		rdchk("ien", 10'h3E4, 32'h0);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_enable;
		apb(1'b1, 10'h200, 32'h01);
		apb(1'b1, 10'h3E4, 32'h8D);
		apb(1'b1, 10'h200, 32'h4B);
		repeat (2) @(posedge mclk);
		chk("outs", 32'hF, {28'h0, flicker_detect_enable, wait_enable,
			spectral_measure_enable, power_on_bit});
		rdchk("enable", 10'h200, 32'h4B);
		apb(1'b1, 10'h200, 32'h02);
		repeat (2) @(posedge mclk);
		chk("spec", 32'h0, {31'h0, spectral_measure_enable});
		$display("t_enable done");
	endtask : t_enable
	task automatic t_mux;
		apb(1'b1, 10'h200, 32'h11);
		@(posedge mclk);
		chk("mux start", 32'h1, {31'h0, ctl_pulse.mux_start});
		repeat (10) @(posedge mclk);
		rdchk("mux clear", 10'h200, 32'h01);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, 10'h3EC, 32'h1F);
		repeat (2) @(posedge mclk);
		chk("irq off", 32'h0, {31'h0, irq});
		$display("t_mux done");
	endtask : t_mux
	task automatic t_irq;
		logic [7:0] ien_tab [4] = '{8'h80, 8'h08, 8'h04, 8'h01};
		ctl_event_t ev_tab [4] = '{5'h10, 5'h08, 5'h04, 5'h02};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 10'h3E4, {24'h0, ien_tab[i]});
			pulse(ev_tab[i]);
			repeat (3) @(posedge mclk);
			chk("irq on", 32'h1, {31'h0, irq});
			apb(1'b1, 10'h3E4, 32'h0);
			repeat (2) @(posedge mclk);
			chk("irq mask", 32'h0, {31'h0, irq});
			apb(1'b1, 10'h3EC, 32'h1F);
		end
		$display("t_irq done");
	endtask : t_irq
	task automatic t_pin_lamp;
		apb(1'b1, 10'h1AC, 32'h0E);
		gpio_pin_in <= 1'b1;
		repeat (5) @(posedge mclk);
		chk("pin out", 32'h0, {31'h0, gpio_pin_out});
		chk("pin oe", 32'h0, {31'h0, gpio_pin_oe});
		rdchk("pin", 10'h1AC, 32'h0F);
		apb(1'b1, 10'h1AC, 32'h02);
		repeat (2) @(posedge mclk);
		chk("pin out", 32'h1, {31'h0, gpio_pin_out});
		rdchk("pin", 10'h1AC, 32'h02);
		apb(1'b1, 10'h334, 32'hFF);
		repeat (2) @(posedge mclk);
		chk("lamp", 32'hFF, {24'h0, lamp_driver_pin, lamp_current_code});
		rdchk("lamp", 10'h334, 32'hFF);
		$display("t_pin_lamp done");
	endtask : t_pin_lamp
	task automatic t_ctl;
		apb(1'b1, 10'h3E8, 32'h07);
		@(posedge mclk);
		chk("pulses", 32'h7, {29'h0, ctl_pulse.autozero,
			ctl_pulse.buffer_clear, ctl_pulse.sleep_exit});
		rdchk("ctl", 10'h3E8, 32'h0);
		pulse(5'h04);
		apb(1'b1, 10'h3E8, 32'h02);
		rdchk("status", 10'h3EC, 32'h0);
		apb(1'b0, 10'h000, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, 10'h3E8, 32'h08);
		@(posedge mclk);
		chk("swrst", 32'h1, {31'h0, ctl_pulse.soft_reset});
		repeat (4) @(posedge mclk);
		rdchk("lamp", 10'h334, 32'h4);
		$display("t_ctl done");
	endtask : t_ctl
	initial begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_enable();
		t_mux();
		t_irq();
		t_pin_lamp();
		t_ctl();
		results();
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		results();
	end
endmodule : sensor_enable_control_regs_test
`default_nettype wire
